// file: rtl/mode_sequencer_boost_ctrl.sv
`timescale 1ns/1ps

module mode_sequencer_boost_ctrl
    import mode_seq_pkg::*;
#(
    parameter int unsigned OSC_SETTLE_CNT      = OSC_SETTLE_CYCLES,
    parameter int unsigned BOOST_SOFTSTART_CNT = BOOST_SOFTSTART_CYCLES
)
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              hard_reset_pin_n,
    input  wire logic              por_active,
    input  wire logic              overtemp_shutdown,
    input  wire logic              reg_wr_en,
    input  wire logic [ADDR_W-1:0] reg_wr_addr,
    input  wire logic [DATA_W-1:0] reg_wr_data,
    input  wire logic              reg_rd_en,
    input  wire logic [ADDR_W-1:0] reg_rd_addr,
    output      logic [DATA_W-1:0] reg_rd_data,
    output      mode_t             mode,
    output      logic              device_reset,
    output      logic              circuits_enable,
    output      logic              boost_enable,
    output      logic              boost_pfm,
    output      logic              boost_pwm,
    output      logic              led_outputs_enable,
    output      logic              active_load_enable,
    output      logic              pulse_skip_allowed,
    output      logic [LEVEL_W-1:0] boost_level_sel,
    output      freq_sel_t         boost_freq_sel
);

    // Whole module state in one record so reset and update stay in one place.
    typedef struct packed {
        logic               pin_meta;
        logic               pin_sync;
        logic               por_meta;
        logic               por_sync;
        logic               tsd_meta;
        logic               tsd_sync;
        logic               soft_reset;
        mode_t              mode;
        logic [DATA_W-1:0]  ctrl;
        logic [DATA_W-1:0]  level;
        logic [DATA_W-1:0]  freq;
        logic               boost_run;
        logic [DATA_W-1:0]  rd_data;
        logic               circuits_en;
        logic               boost_on;
        logic               pfm;
        logic               pwm;
        logic               leds_en;
        logic               active_load;
        logic               skip_ok;
        logic [LEVEL_W-1:0] level_sel;
        freq_sel_t          freq_sel;
    } seq_state_t;

    // Power-up value: the pin synchroniser starts low, so the device sits in
    // reset until the pin has been seen high through both flip-flops.
    localparam seq_state_t STATE_RESET = '{
        pin_meta:    1'b0,
        pin_sync:    1'b0,
        por_meta:    1'b1,
        por_sync:    1'b1,
        tsd_meta:    1'b0,
        tsd_sync:    1'b0,
        soft_reset:  1'b0,
        mode:        MODE_RESET,
        ctrl:        CTRL_RESET,
        level:       LEVEL_RESET,
        freq:        FREQ_RESET,
        boost_run:   1'b0,
        rd_data:     READ_ZERO,
        circuits_en: 1'b0,
        boost_on:    1'b0,
        pfm:         1'b0,
        pwm:         1'b0,
        leds_en:     1'b0,
        active_load: 1'b0,
        skip_ok:     1'b0,
        level_sel:   LEVEL_W'(0),
        freq_sel:    FREQ_NONE
    };

    seq_state_t state_reg;
    seq_state_t state_next;

    logic               dev_reset;
    logic               standby_release;
    logic               en_boost;
    logic               en_autoload;
    logic               timer_clear;
    logic               timer_run;
    logic               timer_expired;
    logic [TIMER_W-1:0] timer_limit;
    logic [LEVEL_W-1:0] level_idx;
    freq_sel_t          freq_dec;
    logic [DATA_W-1:0]  status_word;

    // Internal reset is a level, held for as long as any source is active;
    // the soft reset flag is a single cycle that clears itself.
    assign dev_reset = rst
                     | !state_reg.pin_sync
                     | state_reg.por_sync
                     | state_reg.soft_reset;

    // Control bits as software last wrote them.
    assign standby_release = state_reg.ctrl[CTRL_STANDBY_RELEASE_BIT];
    assign en_boost        = state_reg.ctrl[CTRL_EN_BOOST_BIT];
    assign en_autoload     = state_reg.ctrl[CTRL_EN_AUTOLOAD_BIT];

    // Status word: mode in the low bits, then soft-start, PWM and overtemp.
    assign status_word = {2'b00, state_reg.tsd_sync, state_reg.pwm, state_reg.pfm,
                          state_reg.mode};

    // One counter serves both delays; the limit follows the current mode.
    assign timer_limit = (state_reg.mode == MODE_BOOST_STARTUP)
                       ? TIMER_W'(BOOST_SOFTSTART_CNT)
                       : TIMER_W'(OSC_SETTLE_CNT);

    // The settle delay only counts while no overtemperature is present, so
    // the full 10 ms runs again once the part has cooled down.
    assign timer_run = ((state_reg.mode == MODE_STARTUP) && !state_reg.tsd_sync)
                     || (state_reg.mode == MODE_BOOST_STARTUP);

    // Restart on every mode change, on reset and while overtemperature holds.
    assign timer_clear = dev_reset
                       || (state_next.mode != state_reg.mode)
                       || state_reg.tsd_sync;

    seq_delay_timer u_delay (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (timer_clear),
        .run      (timer_run),
        .limit    (timer_limit),
        .expired  (timer_expired)
    );

    // Decode the held register values; the selects follow a write one edge
    // later, which keeps the decoder out of the next-state loop.
    boost_code_decode u_decode (
        .level_code (state_reg.level),
        .freq_field (state_reg.freq[FREQ_SEL_W-1:0]),
        .level_idx  (level_idx),
        .freq_sel   (freq_dec)
    );

    // Next-state logic: synchronisers, register writes, mode sequencing,
    // read data and the registered outputs.
    always_comb begin
        state_next = state_reg;

        // Pin and analog levels cross into the core clock through two stages.
        state_next.pin_meta = hard_reset_pin_n;
        state_next.pin_sync = state_reg.pin_meta;
        state_next.por_meta = por_active;
        state_next.por_sync = state_reg.por_meta;
        state_next.tsd_meta = overtemp_shutdown;
        state_next.tsd_sync = state_reg.tsd_meta;

        // The soft reset flag lasts one cycle; this default clears it on the next edge.
        state_next.soft_reset = 1'b0;

        if (dev_reset) begin
            // Every register returns to default; the mode parks in reset.
            state_next.mode      = MODE_RESET;
            state_next.ctrl      = CTRL_RESET;
            state_next.level     = LEVEL_RESET;
            state_next.freq      = FREQ_RESET;
            state_next.boost_run = 1'b0;
            state_next.rd_data   = READ_ZERO;
        end else begin
            // Writes are taken in every mode, standby included, and replace
            // the whole byte at once.
            if (reg_wr_en) begin
                if (reg_wr_addr == CTRL_ADDR) begin
                    state_next.ctrl = reg_wr_data & CTRL_MASK;
                end else if (reg_wr_addr == LEVEL_ADDR) begin
                    state_next.level = reg_wr_data;
                end else if (reg_wr_addr == FREQ_ADDR) begin
                    state_next.freq = reg_wr_data;
                end else if (reg_wr_addr == SOFT_RESET_ADDR) begin
                    state_next.soft_reset = 1'b1;
                end
            end

            // Mode sequencing. The standby release bit is checked first so
            // that clearing it wins over every other transition.
            case (state_reg.mode)
                MODE_RESET: begin
                    state_next.mode = MODE_STANDBY;
                end
                MODE_STANDBY: begin
                    state_next.boost_run = 1'b0;
                    if (standby_release) begin
                        state_next.mode = MODE_STARTUP;
                    end
                end
                MODE_STARTUP: begin
                    state_next.boost_run = 1'b0;
                    if (!standby_release) begin
                        state_next.mode = MODE_STANDBY;
                    end else if (state_reg.tsd_sync) begin
                        state_next.mode = MODE_STARTUP;
                    end else if (timer_expired) begin
                        if (en_boost) begin
                            state_next.mode = MODE_BOOST_STARTUP;
                        end else begin
                            state_next.mode = MODE_NORMAL;
                        end
                    end
                end
                MODE_BOOST_STARTUP: begin
                    if (!standby_release) begin
                        state_next.mode      = MODE_STANDBY;
                        state_next.boost_run = 1'b0;
                    end else if (state_reg.tsd_sync) begin
                        state_next.mode      = MODE_STARTUP;
                        state_next.boost_run = 1'b0;
                    end else if (!en_boost) begin
                        // Soft-start abandoned; the rest of the chip runs on.
                        state_next.mode      = MODE_NORMAL;
                        state_next.boost_run = 1'b0;
                    end else if (timer_expired) begin
                        state_next.mode      = MODE_NORMAL;
                        state_next.boost_run = 1'b1;
                    end
                end
                MODE_NORMAL: begin
                    if (!standby_release) begin
                        state_next.mode      = MODE_STANDBY;
                        state_next.boost_run = 1'b0;
                    end else if (state_reg.tsd_sync) begin
                        state_next.mode      = MODE_STARTUP;
                        state_next.boost_run = 1'b0;
                    end else if (!en_boost) begin
                        state_next.boost_run = 1'b0;
                    end else if (!state_reg.boost_run) begin
                        // Enable seen high while the boost is idle: soft-start.
                        state_next.mode = MODE_BOOST_STARTUP;
                    end
                end
                default: begin
                    state_next.mode      = MODE_RESET;
                    state_next.boost_run = 1'b0;
                end
            endcase

            // Read data is captured on the request and held until the next.
            if (reg_rd_en) begin
                if (reg_rd_addr == CTRL_ADDR) begin
                    state_next.rd_data = state_reg.ctrl;
                end else if (reg_rd_addr == STATUS_ADDR) begin
                    state_next.rd_data = status_word;
                end else if (reg_rd_addr == LEVEL_ADDR) begin
                    state_next.rd_data = state_reg.level;
                end else if (reg_rd_addr == FREQ_ADDR) begin
                    state_next.rd_data = state_reg.freq;
                end else begin
                    // Write-only reset register and unmapped offsets read zero.
                    state_next.rd_data = READ_ZERO;
                end
            end
        end

        // Outputs derive from the next mode so they change with it, not after.
        state_next.circuits_en = (state_next.mode != MODE_RESET)
                              && (state_next.mode != MODE_STANDBY);
        state_next.pfm = (state_next.mode == MODE_BOOST_STARTUP);
        state_next.pwm = (state_next.mode == MODE_NORMAL)
                      && state_next.boost_run;
        state_next.boost_on = state_next.pfm || state_next.pwm;
        // LEDs only in normal mode: dark during soft-start and standby.
        state_next.leds_en = (state_next.mode == MODE_NORMAL);
        state_next.active_load = state_next.boost_on
                              && state_next.ctrl[CTRL_EN_AUTOLOAD_BIT];
        state_next.skip_ok = state_next.boost_on
                          && !state_next.ctrl[CTRL_EN_AUTOLOAD_BIT];
        // Level and frequency settings reach the selects one edge after the register write;
        // the analog side ignores them while the boost is off.
        state_next.level_sel = level_idx;
        state_next.freq_sel  = freq_dec;
    end

    // Single register stage for the whole module state.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the state register; device_reset decodes the registered mode.
    assign reg_rd_data        = state_reg.rd_data;
    assign mode               = state_reg.mode;
    assign device_reset       = (state_reg.mode == MODE_RESET);
    assign circuits_enable    = state_reg.circuits_en;
    assign boost_enable       = state_reg.boost_on;
    assign boost_pfm          = state_reg.pfm;
    assign boost_pwm          = state_reg.pwm;
    assign led_outputs_enable = state_reg.leds_en;
    assign active_load_enable = state_reg.active_load;
    assign pulse_skip_allowed = state_reg.skip_ok;
    assign boost_level_sel    = state_reg.level_sel;
    assign boost_freq_sel     = state_reg.freq_sel;

endmodule : mode_sequencer_boost_ctrl

// file: pkg/mode_seq_pkg.sv
package mode_seq_pkg;

    // Core clock rate in kHz and the two sequencer delays in milliseconds.
    localparam int unsigned CORE_CLK_KHZ       = 200000;
    localparam int unsigned OSC_SETTLE_MS      = 10;
    localparam int unsigned BOOST_SOFTSTART_MS = 10;

    // Delay counts in core clock cycles, derived from the times above.
    localparam int unsigned OSC_SETTLE_CYCLES      = OSC_SETTLE_MS * CORE_CLK_KHZ;
    localparam int unsigned BOOST_SOFTSTART_CYCLES = BOOST_SOFTSTART_MS * CORE_CLK_KHZ;

    // Delay counter width; it covers the full 10 ms count with margin.
    localparam int unsigned TIMER_W = 22;

    // Register port geometry.
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets.
    localparam logic [7:0] CTRL_ADDR       = 8'h0B;
    localparam logic [7:0] STATUS_ADDR     = 8'h0C;
    localparam logic [7:0] LEVEL_ADDR      = 8'h0D;
    localparam logic [7:0] FREQ_ADDR       = 8'h0E;
    localparam logic [7:0] SOFT_RESET_ADDR = 8'h60;

    // Reset values and writable masks.
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] CTRL_MASK   = 8'h07;
    localparam logic [7:0] LEVEL_RESET = 8'h3F;
    localparam logic [7:0] FREQ_RESET  = 8'h07;
    localparam logic [7:0] READ_ZERO   = 8'h00;

    // Control register bit positions.
    localparam int unsigned CTRL_STANDBY_RELEASE_BIT = 0;
    localparam int unsigned CTRL_EN_BOOST_BIT        = 1;
    localparam int unsigned CTRL_EN_AUTOLOAD_BIT     = 2;

    // Frequency select field occupies the low bits of the frequency register.
    localparam int unsigned FREQ_SEL_W = 3;

    // Output level index: nine thermometer steps, 0 to 8.
    localparam int unsigned LEVEL_W = 4;

    // Operating modes.
    typedef enum logic [2:0] {
        MODE_RESET         = 3'b000,
        MODE_STANDBY       = 3'b001,
        MODE_STARTUP       = 3'b010,
        MODE_BOOST_STARTUP = 3'b011,
        MODE_NORMAL        = 3'b100
    } mode_t;

    // Decoded switching frequency.
    typedef enum logic [1:0] {
        FREQ_NONE = 2'b00,
        FREQ_1M00 = 2'b01,
        FREQ_1M67 = 2'b10,
        FREQ_2M00 = 2'b11
    } freq_sel_t;

endpackage : mode_seq_pkg

// file: rtl/seq_delay_timer.sv
`timescale 1ns/1ps

// Cycle counter for the sequencer delays; expired holds once the limit is reached.
module seq_delay_timer
    import mode_seq_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               clear,
    input  wire logic               run,
    input  wire logic [TIMER_W-1:0] limit,
    output      logic               expired
);

    typedef struct packed {
        logic [TIMER_W-1:0] count;
    } timer_state_t;

    timer_state_t state_reg;
    timer_state_t state_next;

    // A limit of zero is treated as one cycle so the delay never vanishes.
    assign expired = (state_reg.count + TIMER_W'(1)) >= limit;

    // Clear wins over run, so a restarted delay always begins from zero.
    always_comb begin
        state_next = state_reg;
        if (clear) begin
            state_next.count = '0;
        end else if (run && !expired) begin
            state_next.count = state_reg.count + TIMER_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : seq_delay_timer

// file: rtl/boost_code_decode.sv
`timescale 1ns/1ps

// Decodes the output level thermometer code and the frequency select field.
module boost_code_decode
    import mode_seq_pkg::*;
(
    input  wire logic [DATA_W-1:0]     level_code,
    input  wire logic [FREQ_SEL_W-1:0] freq_field,
    output      logic [LEVEL_W-1:0]    level_idx,
    output      freq_sel_t             freq_sel
);

    logic [DATA_W-1:0] ones_run;

    // Only the unbroken run of ones from bit 0 counts, so a malformed code
    // selects the level of its valid low part rather than a higher one.
    assign ones_run[0] = level_code[0];
    generate
        for (genvar i = 1; i < DATA_W; i++) begin : g_run
            assign ones_run[i] = ones_run[i-1] & level_code[i];
        end
    endgenerate

    assign level_idx = LEVEL_W'($countones(ones_run));

    // Highest set bit wins; an all-zero field selects no frequency.
    always_comb begin
        if (freq_field[2]) begin
            freq_sel = FREQ_2M00;
        end else if (freq_field[1]) begin
            freq_sel = FREQ_1M67;
        end else if (freq_field[0]) begin
            freq_sel = FREQ_1M00;
        end else begin
            freq_sel = FREQ_NONE;
        end
    end

endmodule : boost_code_decode

// file: test/mode_seq_chk.sv
`timescale 1ns/1ps

// Port-level checks of the mode sequencer; all of them sit in the core clock domain.
module mode_seq_chk
    import mode_seq_pkg::*;
#(
    parameter int unsigned OSC_SETTLE_CNT      = 20,
    parameter int unsigned BOOST_SOFTSTART_CNT = 20
)
(
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              hard_reset_pin_n,
    input wire logic              por_active,
    input wire logic              overtemp_shutdown,
    input wire logic              reg_wr_en,
    input wire logic [ADDR_W-1:0] reg_wr_addr,
    input wire logic [DATA_W-1:0] reg_wr_data,
    input wire mode_t             mode,
    input wire logic              device_reset,
    input wire logic              circuits_enable,
    input wire logic              boost_enable,
    input wire logic              boost_pfm,
    input wire logic              boost_pwm,
    input wire logic              led_outputs_enable
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Cycles spent in one mode; overtemperature restarts it because the design's delay restarts.
    logic [23:0] stay_reg;
    mode_t       mode_q;
    always_ff @(posedge core_clk) begin
        mode_q <= mode;
        if (rst || mode != mode_q || overtemp_shutdown) begin
            stay_reg <= 24'h0;
        end else begin
            stay_reg <= stay_reg + 24'h1;
        end
    end

    // Writes that are taken only outside reset.
    sequence s_soft_wr;
        reg_wr_en && reg_wr_addr == SOFT_RESET_ADDR && mode != MODE_RESET;
    endsequence
    sequence s_clr_wr;
        reg_wr_en && reg_wr_addr == CTRL_ADDR && !reg_wr_data[0] && mode != MODE_RESET;
    endsequence

    property p_soft_reset;
        s_soft_wr |-> ##2 mode == MODE_RESET ##1 mode == MODE_STANDBY;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset sequence wrong");
    property p_pin_reset;
        !hard_reset_pin_n [*4] |-> device_reset && !circuits_enable;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("reset pin not honoured");
    property p_por;
        por_active [*4] |-> device_reset;
    endproperty
    a_por: assert property (p_por) else $error("power-on reset not honoured");
    property p_standby_off;
        mode == MODE_STANDBY |-> !circuits_enable && !boost_enable && !led_outputs_enable;
    endproperty
    a_standby_off: assert property (p_standby_off) else $error("standby left circuits on");
    property p_settle;
        mode_q == MODE_STARTUP && mode inside {MODE_NORMAL, MODE_BOOST_STARTUP}
            |-> stay_reg + 3 >= OSC_SETTLE_CNT && stay_reg <= OSC_SETTLE_CNT + 3;
    endproperty
    a_settle: assert property (p_settle) else $error("startup delay length wrong");
    property p_softstart;
        mode_q == MODE_BOOST_STARTUP && mode == MODE_NORMAL && boost_enable
            |-> boost_pwm && stay_reg + 3 >= BOOST_SOFTSTART_CNT;
    endproperty
    a_softstart: assert property (p_softstart) else $error("soft-start end wrong");
    property p_pfm;
        mode == MODE_BOOST_STARTUP |-> boost_pfm && !boost_pwm && !led_outputs_enable;
    endproperty
    a_pfm: assert property (p_pfm) else $error("soft-start outputs wrong");
    property p_overtemp;
        overtemp_shutdown [*4] ##0 circuits_enable |-> mode == MODE_STARTUP && !boost_enable;
    endproperty
    a_overtemp: assert property (p_overtemp) else $error("overtemperature not honoured");
    property p_standby_clr;
        s_clr_wr |-> ##2 mode inside {MODE_STANDBY, MODE_RESET};
    endproperty
    a_standby_clr: assert property (p_standby_clr) else $error("standby not re-entered");
endmodule : mode_seq_chk

bind mode_sequencer_boost_ctrl mode_seq_chk #(
    .OSC_SETTLE_CNT(OSC_SETTLE_CNT),
    .BOOST_SOFTSTART_CNT(BOOST_SOFTSTART_CNT)
) i_mode_seq_chk (.*);

// file: test/host_model.sv
`timescale 1ns/1ps

// Host on the register port; strobes change only at the falling edge and last one cycle.
module host_model
    import mode_seq_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic [DATA_W-1:0] reg_rd_data,
    output      logic              reg_wr_en,
    output      logic [ADDR_W-1:0] reg_wr_addr,
    output      logic [DATA_W-1:0] reg_wr_data,
    output      logic              reg_rd_en,
    output      logic [ADDR_W-1:0] reg_rd_addr
);
    // Idle values park the address away from every mapped offset.
    initial begin
        reg_wr_en   = 1'b0;
        reg_wr_addr = 8'hFF;
        reg_wr_data = 8'h00;
        reg_rd_en   = 1'b0;
        reg_rd_addr = 8'hFF;
    end

    // One whole byte per write; any register may follow any other.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr_en   = 1'b1;
        reg_wr_addr = a;
        reg_wr_data = d;
        @(negedge core_clk);
        reg_wr_en   = 1'b0;
    endtask : wr

    // Read data is registered, so it is taken one edge after the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_rd_en   = 1'b1;
        reg_rd_addr = a;
        @(negedge core_clk);
        reg_rd_en   = 1'b0;
        d           = reg_rd_data;
    endtask : rd
endmodule : host_model

// file: test/tb_mode_sequencer_boost_ctrl.sv
`timescale 1ns/1ps

// Bench with shortened delays so that each sequence takes a few dozen cycles.
module tb_mode_sequencer_boost_ctrl
    import mode_seq_pkg::*;
;
    localparam int unsigned N = 20;
    logic       core_clk = 1'b0, rst = 1'b1, hard_reset_pin_n = 1'b1;
    logic       por_active = 1'b0, overtemp_shutdown = 1'b0;
    logic       reg_wr_en, reg_rd_en, device_reset, circuits_enable, boost_enable;
    logic       boost_pfm, boost_pwm, led_outputs_enable, active_load_enable, pulse_skip_allowed;
    logic [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data;
    logic [3:0] boost_level_sel;
    mode_t      mode;
    freq_sel_t  boost_freq_sel;
    int         num_errors = 0, checked = 0;

    mode_sequencer_boost_ctrl #(.OSC_SETTLE_CNT(N), .BOOST_SOFTSTART_CNT(N))
        i_mode_sequencer_boost_ctrl (.*);
    host_model i_host_model (.*);

    always #2.5 core_clk = ~core_clk;

    task automatic test_done;
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host_model.rd(a, d);
        chk(e, d);
    endtask : rchk

    task automatic wait_mode(input mode_t m, output int n);
        n = 0;
        while (mode !== m && n < 500) begin
            @(negedge core_clk);
            n++;
        end
        chk(8'(m), 8'(mode));
    endtask : wait_mode

    task automatic t_defaults;
        chk(8'(MODE_STANDBY), 8'(mode));
        rchk(CTRL_ADDR, 8'h00);
        rchk(LEVEL_ADDR, 8'h3F);
        rchk(FREQ_ADDR, 8'h07);
        rchk(SOFT_RESET_ADDR, 8'h00);
        rchk(8'h5A, 8'h00);
        chk(8'h06, 8'(boost_level_sel));
        chk(8'(FREQ_2M00), 8'(boost_freq_sel));
    endtask : t_defaults

    task automatic t_codes;
        freq_sel_t fe;
        for (int i = 0; i <= 8; i++) begin
            i_host_model.wr(LEVEL_ADDR, 8'((9'h1 << i) - 9'h1));
            @(negedge core_clk);
            chk(8'(i), 8'(boost_level_sel));
        end
        for (int f = 0; f < 8; f++) begin
            i_host_model.wr(FREQ_ADDR, 8'(f));
            @(negedge core_clk);
            fe = f > 3 ? FREQ_2M00 : (f > 1 ? FREQ_1M67 : (f > 0 ? FREQ_1M00 : FREQ_NONE));
            chk(8'(fe), 8'(boost_freq_sel));
        end
        chk(8'(MODE_STANDBY), 8'(mode));
    endtask : t_codes

    task automatic t_startup;
        int n;
        i_host_model.wr(CTRL_ADDR, 8'h01);
        wait_mode(MODE_NORMAL, n);
        chk(8'h01, 8'(n >= N - 2 && n <= N + 4));
        chk(8'h01, 8'(led_outputs_enable));
        i_host_model.wr(CTRL_ADDR, 8'h03);
        wait_mode(MODE_BOOST_STARTUP, n);
        chk(8'h02, 8'({boost_pfm, led_outputs_enable}));
        wait_mode(MODE_NORMAL, n);
        chk(8'h01, 8'(n >= N - 3 && n <= N + 3));
        chk(8'h06, 8'({boost_pwm, pulse_skip_allowed, active_load_enable}));
        i_host_model.wr(CTRL_ADDR, 8'h07);
        @(negedge core_clk);
        chk(8'h02, 8'({active_load_enable, pulse_skip_allowed}));
        i_host_model.wr(CTRL_ADDR, 8'h05);
        @(negedge core_clk);
        chk(8'(MODE_NORMAL), 8'({boost_enable, 3'(mode)}));
    endtask : t_startup

    // Overheating in normal mode with the boost on, then recovery through startup until soft-start begins.
    task automatic t_overtemp;
        int n;
        i_host_model.wr(CTRL_ADDR, 8'h03);
        wait_mode(MODE_BOOST_STARTUP, n);
        wait_mode(MODE_NORMAL, n);
        overtemp_shutdown = 1'b1;
        repeat (3 * N) @(negedge core_clk);
        chk(8'(MODE_STARTUP), 8'({boost_enable, 3'(mode)}));
        overtemp_shutdown = 1'b0;
        wait_mode(MODE_BOOST_STARTUP, n);
        chk(8'h01, 8'(n >= N - 2 && n <= N + 6));
        i_host_model.wr(CTRL_ADDR, 8'h00);
        repeat (2) @(negedge core_clk);
        chk(8'(MODE_STANDBY), 8'({circuits_enable, 3'(mode)}));
    endtask : t_overtemp

    task automatic t_resets;
        int n;
        i_host_model.wr(LEVEL_ADDR, 8'h01);
        hard_reset_pin_n = 1'b0;
        repeat (5) @(negedge core_clk);
        chk(8'h01, 8'(device_reset));
        hard_reset_pin_n = 1'b1;
        por_active = 1'b1;
        repeat (5) @(negedge core_clk);
        chk(8'h01, 8'(device_reset));
        por_active = 1'b0;
        wait_mode(MODE_STANDBY, n);
        rchk(LEVEL_ADDR, 8'h3F);
        i_host_model.wr(CTRL_ADDR, 8'h01);
        i_host_model.wr(SOFT_RESET_ADDR, 8'hA5);
        wait_mode(MODE_RESET, n);
        repeat (2) @(negedge core_clk);
        rchk(CTRL_ADDR, 8'h00);
    endtask : t_resets

    // Main sequence; reset is released at a falling edge after 12 cycles.
    initial begin
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        t_defaults;
        t_codes;
        t_startup;
        t_overtemp;
        t_resets;
        test_done;
    end

    // The whole run needs well under a thousand cycles; this cuts a hang short.
    initial begin
        #50000;
        num_errors++;
        test_done;
    end
endmodule : tb_mode_sequencer_boost_ctrl
